// ### core/dacl_map.vh
// Register offsets, field positions, entry layout and reset values for the array-chain fetcher
`ifndef DACL_MAP_VH
`define DACL_MAP_VH
// ****************************************
// Register port
// ****************************************
`define DACL_REG_AW 5
`define DACL_OFS_NEXT_ADDR_UPPER 5'h1f
`define DACL_OFS_NEXT_ADDR_LOWER 5'h1e
`define DACL_OFS_CONTROL 5'h1d
`define DACL_OFS_STATUS 5'h1c
`define DACL_OFS_BYTE_COUNT 5'h1b
`define DACL_OFS_ADDR_UPPER 5'h1a
`define DACL_OFS_ADDR_LOWER 5'h19
`define DACL_OFS_FRAME_WORD 5'h18
`define DACL_OFS_CHAR_WORD 5'h17
// ****************************************
// Control fields
// ****************************************
`define DACL_CTL_START 0
`define DACL_CTL_BUS8 1
`define DACL_CTL_STATUS_EN 2
`define DACL_CTL_LITTLE 12
`define DACL_CTL_RESET 16'h0000
// ****************************************
// Entry layout
// ****************************************
`define DACL_ENTRY_BYTES 5'h06
`define DACL_ENTRY_BYTES_EXT 5'h0c
`define DACL_OFS_CNT 5'h04
`define DACL_OFS_EXT_FRAME 5'h06
`define DACL_OFS_EXT_CHAR 5'h08
`define DACL_OFS_EXT_ZERO 5'h0a
`endif

// ### core/dacl_assemble.v
// Places one fetched memory byte or word into the address or count field of an entry
`timescale 1ns/1ns
`include "dacl_map.vh"
module dacl_assemble (
  input wire [4:0] ofs_i,
  input wire [15:0] data_i,
  input wire bus8_i,
  input wire little_i,
  input wire [31:0] addr_in_i,
  input wire [15:0] cnt_in_i,
  output reg [31:0] addr_o,
  output reg [15:0] cnt_o
);
  always @* begin
    addr_o = addr_in_i;
    cnt_o = cnt_in_i;
    if (!bus8_i) begin
      if (ofs_i == 5'h00) begin
        if (little_i) addr_o[15:0] = data_i;
        else addr_o[31:16] = data_i;
      end else if (ofs_i == 5'h02) begin
        if (little_i) addr_o[31:16] = data_i;
        else addr_o[15:0] = data_i;
      end else if (ofs_i == `DACL_OFS_CNT) begin
        cnt_o = data_i;
      end
    end else begin
      // Byte lanes: big end walks high to low, little end low to high
      case (ofs_i)
        5'h00: if (little_i) addr_o[7:0] = data_i[7:0]; else addr_o[31:24] = data_i[7:0];
        5'h01: if (little_i) addr_o[15:8] = data_i[7:0]; else addr_o[23:16] = data_i[7:0];
        5'h02: if (little_i) addr_o[23:16] = data_i[7:0]; else addr_o[15:8] = data_i[7:0];
        5'h03: if (little_i) addr_o[31:24] = data_i[7:0]; else addr_o[7:0] = data_i[7:0];
        5'h04: if (little_i) cnt_o[7:0] = data_i[7:0]; else cnt_o[15:8] = data_i[7:0];
        5'h05: if (little_i) cnt_o[15:8] = data_i[7:0]; else cnt_o[7:0] = data_i[7:0];
        default: addr_o = addr_in_i;
      endcase
    end
  end
endmodule // dacl_assemble

// ### core/dacl_array_chain.v
// Array-chained descriptor fetcher for one DMA channel
`timescale 1ns/1ns
`include "dacl_map.vh"
// What this block does
// - 16-bit big end: upper, lower, count
// - 16-bit little end: lower, upper, count
// - 8-bit in either byte order, six bytes
// - Zero count entry ends chaining, address unused
// - Status mode: twelve-byte entries with extras
// - Extra words identical for both byte orders
// - One control bit picks byte order
module dacl_array_chain (
  input wire core_clk_i,
  input wire resetn_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [4:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  output reg mem_req_o,
  output reg [31:0] mem_addr_o,
  output reg mem_wide_o,
  input wire mem_ack_i,
  input wire [15:0] mem_rdata_i,
  output reg buf_valid_o,
  output reg [31:0] buf_addr_o,
  output reg [15:0] buf_count_o,
  output reg [15:0] buf_frame_o,
  output reg [15:0] buf_char_o,
  input wire buf_done_i,
  output reg busy_o,
  output reg chain_end_o
);
  // ****************************************
  // Reset release
  // ****************************************
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Walk states
  localparam ST_IDLE = 2'd0;
  localparam ST_FETCH = 2'd1;
  localparam ST_USE = 2'd2;

  reg [1:0] state_q;
  reg [15:0] ctl_q;
  reg [31:0] base_q;
  reg [31:0] ent_addr_q;
  reg [15:0] ent_cnt_q;
  reg [15:0] ent_frame_q;
  reg [15:0] ent_char_q;
  reg [4:0] ofs_q;
  reg done_q;
  wire [31:0] asm_addr;
  wire [15:0] asm_cnt;
  // Mode bits only change while idle, so a chain never sees its layout shift under it
  wire bus8 = ctl_q[`DACL_CTL_BUS8];
  wire little = ctl_q[`DACL_CTL_LITTLE];
  wire ext = ctl_q[`DACL_CTL_STATUS_EN];
  wire [4:0] step = bus8 ? 5'h01 : 5'h02;
  wire [4:0] ent_len = ext ? `DACL_ENTRY_BYTES_EXT : `DACL_ENTRY_BYTES;
  wire [4:0] ofs_next = ofs_q + step;

  // ****************************************
  // Control decode
  // ****************************************
  // Control writes are dropped unless idle; a start mid-chain would tear a half-read entry
  wire wr_idle = reg_wr_i && state_q == ST_IDLE;
  wire start_hit = wr_idle && reg_addr_i == `DACL_OFS_CONTROL && reg_wdata_i[`DACL_CTL_START];
  wire fetch_last = ofs_next >= ent_len;
  wire dummy_hit = ofs_next == `DACL_ENTRY_BYTES && asm_cnt == 16'h0000;

  // Either byte of a two-byte field on the byte bus, or the whole word on the wide bus
  function pair_hit;
    input [4:0] ofs;
    input [4:0] first;
    begin
      pair_hit = ofs == first || ofs == first + 5'h01;
    end
  endfunction

  // Extra words are always high byte first, whatever the order bit says
  function [15:0] put_ext;
    input [15:0] old;
    input [15:0] d;
    input is8;
    input hi;
    begin
      if (!is8) put_ext = d;
      else if (hi) put_ext = {d[7:0], old[7:0]};
      else put_ext = {old[15:8], d[7:0]};
    end
  endfunction

  dacl_assemble u_asm (
    .ofs_i(ofs_q),
    .data_i(mem_rdata_i),
    .bus8_i(bus8),
    .little_i(little),
    .addr_in_i(ent_addr_q),
    .cnt_in_i(ent_cnt_q),
    .addr_o(asm_addr),
    .cnt_o(asm_cnt)
  );

  // ****************************************
  // Entry walk
  // ****************************************
  always @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      ctl_q <= `DACL_CTL_RESET;
      base_q <= 32'h00000000;
      ent_addr_q <= 32'h00000000;
      ent_cnt_q <= 16'h0000;
      ent_frame_q <= 16'h0000;
      ent_char_q <= 16'h0000;
      ofs_q <= 5'h00;
      done_q <= 1'b0;
      mem_req_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      // Wide bus shown at reset, as the control reset selects it
      mem_wide_o <= 1'b1;
      buf_valid_o <= 1'b0;
      buf_addr_o <= 32'h00000000;
      buf_count_o <= 16'h0000;
      buf_frame_o <= 16'h0000;
      buf_char_o <= 16'h0000;
      busy_o <= 1'b0;
      chain_end_o <= 1'b0;
      reg_rdata_o <= 16'h0000;
    end else begin
      mem_wide_o <= ~bus8;
      if (wr_idle) begin
        if (reg_addr_i == `DACL_OFS_NEXT_ADDR_UPPER) base_q[31:16] <= reg_wdata_i;
        else if (reg_addr_i == `DACL_OFS_NEXT_ADDR_LOWER) base_q[15:0] <= reg_wdata_i;
        else if (reg_addr_i == `DACL_OFS_CONTROL) ctl_q <= reg_wdata_i & 16'h1006;
      end
      if (start_hit) begin
        state_q <= ST_FETCH;
        ofs_q <= 5'h00;
        done_q <= 1'b0;
        busy_o <= 1'b1;
        chain_end_o <= 1'b0;
        mem_req_o <= 1'b1;
        // The new width goes out with the first request, not one cycle behind it
        mem_wide_o <= ~reg_wdata_i[`DACL_CTL_BUS8];
        mem_addr_o <= base_q;
        ent_cnt_q <= 16'h0000;
      end
      case (state_q)
        ST_FETCH: begin
          if (mem_ack_i) begin
            ent_addr_q <= asm_addr;
            ent_cnt_q <= asm_cnt;
            if (pair_hit(ofs_q, `DACL_OFS_EXT_FRAME))
              ent_frame_q <= put_ext(ent_frame_q, mem_rdata_i, bus8, ofs_q == `DACL_OFS_EXT_FRAME);
            if (pair_hit(ofs_q, `DACL_OFS_EXT_CHAR))
              ent_char_q <= put_ext(ent_char_q, mem_rdata_i, bus8, ofs_q == `DACL_OFS_EXT_CHAR);
            // Zero word at the tail is read to keep the stride but discarded
            // A zero count ends the walk before any extra word of the dummy is fetched
            if (dummy_hit) begin
              state_q <= ST_IDLE;
              mem_req_o <= 1'b0;
              busy_o <= 1'b0;
              chain_end_o <= 1'b1;
              done_q <= 1'b1;
            end else if (fetch_last) begin
              state_q <= ST_USE;
              mem_req_o <= 1'b0;
              buf_valid_o <= 1'b1;
              buf_addr_o <= asm_addr;
              buf_count_o <= asm_cnt;
              buf_frame_o <= ent_frame_q;
              buf_char_o <= ent_char_q;
            end else begin
              ofs_q <= ofs_next;
              mem_addr_o <= base_q + {27'h0000000, ofs_next};
            end
          end
        end
        ST_USE: begin
          if (buf_done_i) begin
            buf_valid_o <= 1'b0;
            // Base moves only once an entry is consumed, so it always names the entry in use
            base_q <= base_q + {27'h0000000, ent_len};
            ofs_q <= 5'h00;
            state_q <= ST_FETCH;
            mem_req_o <= 1'b1;
            mem_addr_o <= base_q + {27'h0000000, ent_len};
            ent_cnt_q <= 16'h0000;
          end
        end
        default: begin
          if (chain_end_o && reg_rd_i && reg_addr_i == `DACL_OFS_STATUS) chain_end_o <= 1'b0;
        end
      endcase
      // ****************************************
      // Register reads
      // ****************************************
      // Read data follows the address every cycle; only the status read has a side effect
      if (reg_addr_i == `DACL_OFS_NEXT_ADDR_UPPER) reg_rdata_o <= base_q[31:16];
      else if (reg_addr_i == `DACL_OFS_NEXT_ADDR_LOWER) reg_rdata_o <= base_q[15:0];
      else if (reg_addr_i == `DACL_OFS_CONTROL) reg_rdata_o <= ctl_q;
      else if (reg_addr_i == `DACL_OFS_STATUS) reg_rdata_o <= {14'h0000, done_q, busy_o};
      else if (reg_addr_i == `DACL_OFS_BYTE_COUNT) reg_rdata_o <= buf_count_o;
      else if (reg_addr_i == `DACL_OFS_ADDR_UPPER) reg_rdata_o <= buf_addr_o[31:16];
      else if (reg_addr_i == `DACL_OFS_ADDR_LOWER) reg_rdata_o <= buf_addr_o[15:0];
      else if (reg_addr_i == `DACL_OFS_FRAME_WORD) reg_rdata_o <= buf_frame_o;
      else if (reg_addr_i == `DACL_OFS_CHAR_WORD) reg_rdata_o <= buf_char_o;
      else reg_rdata_o <= 16'h0000;
    end
  end
endmodule // dacl_array_chain

// ### testbench/dacl_array_chain_monitor.sv
// Checker for the array-chain fetcher ports
`timescale 1ns/1ns
module dacl_array_chain_monitor (
  input wire core_clk_i,
  input wire resetn_i,
  input wire mem_req_o,
  input wire [31:0] mem_addr_o,
  input wire mem_wide_o,
  input wire mem_ack_i,
  input wire buf_valid_o,
  input wire [31:0] buf_addr_o,
  input wire [15:0] buf_count_o,
  input wire buf_done_i,
  input wire busy_o,
  input wire chain_end_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  fetch_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("fetch request changed before its answer");
  word_step_a: assert property (mem_req_o && mem_ack_i && mem_wide_o ##1 mem_req_o |->
    mem_addr_o == $past(mem_addr_o) + 32'h2) else $error("word fetch did not step by two");
  byte_step_a: assert property (mem_req_o && mem_ack_i && !mem_wide_o ##1 mem_req_o |->
    mem_addr_o == $past(mem_addr_o) + 32'h1) else $error("byte fetch did not step by one");
  end_quiet_a: assert property ($rose(chain_end_o) |-> !busy_o && !mem_req_o && !buf_valid_o)
    else $error("chain end left activity behind");
  idle_end_a: assert property ($fell(busy_o) |-> chain_end_o) else $error("chain stopped without its end");
  entry_live_a: assert property ($rose(buf_valid_o) |-> buf_count_o != 16'h0000)
    else $error("zero count entry handed out");
  entry_hold_a: assert property (buf_valid_o && !buf_done_i |=> buf_valid_o && $stable(buf_addr_o))
    else $error("entry changed while offered");
  entry_next_a: assert property (buf_valid_o && buf_done_i |=> !buf_valid_o ##[0:2] mem_req_o)
    else $error("consumed entry did not lead to a fetch");
  width_fixed_a: assert property (busy_o && $past(busy_o) |-> $stable(mem_wide_o))
    else $error("bus width changed within a chain");
  cover property ($rose(chain_end_o));
  cover property (buf_valid_o && buf_done_i);
  cover property (mem_req_o && mem_ack_i && !mem_wide_o);
endmodule // dacl_array_chain_monitor
bind dacl_array_chain dacl_array_chain_monitor dacl_array_chain_monitor_i (.core_clk_i, .resetn_i,
  .mem_req_o, .mem_addr_o, .mem_wide_o, .mem_ack_i, .buf_valid_o, .buf_addr_o, .buf_count_o,
  .buf_done_i, .busy_o, .chain_end_o);

// ### testbench/dacl_mem_model.sv
// Memory model answering descriptor fetches
`timescale 1ns/1ns
module dacl_mem_model (
  input wire clk_i,
  input wire [1:0] lat_i,
  input wire req_i,
  input wire [31:0] addr_i,
  input wire wide_i,
  output logic ack_o,
  output logic [15:0] data_o
);
  logic [7:0] mem [0:255];
  int wait_q = 0;
  initial ack_o = 1'b0;
  initial data_o = 16'h0000;
  // Data toggles when not answering, so a stale word never passes for a fresh one
  always @(posedge clk_i) begin
    #2;
    if (ack_o || !req_i) begin
      ack_o = 1'b0;
      wait_q = 0;
      data_o = ~data_o;
    end else if (wait_q < lat_i) begin
      wait_q++;
      data_o = ~data_o;
    end else begin
      ack_o = 1'b1;
      data_o = wide_i ? {mem[addr_i[7:0]], mem[addr_i[7:0] + 8'h01]} : {~data_o[15:8], mem[addr_i[7:0]]};
    end
  end
endmodule // dacl_mem_model

// ### testbench/dacl_array_chain_bench.sv
// Self-checking bench for the array-chain fetcher
`timescale 1ns/1ns
`include "dacl_map.vh"
module dacl_array_chain_bench;
  logic core_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, buf_done_i = 0, mem_ack_i, mem_req_o, mem_wide_o;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, mem_rdata_i, buf_count_o, buf_frame_o, buf_char_o, rv;
  logic [31:0] mem_addr_o, buf_addr_o;
  logic [1:0] lat = 2'h0;
  logic busy_o, chain_end_o, buf_valid_o;
  logic [79:0] x;
  logic [79:0] exp_q [$];
  int errors = 0, checks_done = 0, seed = 57830, k, m, b, e;
  always #25 core_clk_i = ~core_clk_i;
  dacl_array_chain dacl_array_chain_i (.*);
  dacl_mem_model dacl_mem_model_i (.clk_i(core_clk_i), .lat_i(lat), .req_i(mem_req_o), .addr_i(mem_addr_o),
    .wide_i(mem_wide_o), .ack_o(mem_ack_i), .data_o(mem_rdata_i));
  task tick; @(posedge core_clk_i) #2; endtask
  task chk(input logic [47:0] s, input logic [47:0] w);
    checks_done++;
    if (s !== w) begin
      errors++;
      $display("unexpected at %0t: %h expected %h", $time, s, w);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    tick;
    reg_wr_i = 0;
    tick;
  endtask
  task rd(input logic [4:0] a);
    reg_addr_i = a;
    reg_rd_i = 1;
    tick;
    reg_rd_i = 0;
    rv = reg_rdata_o;
    tick;
  endtask
  // Lays one entry into memory in the byte order the mode calls for
  task put(input int a, input logic [79:0] v);
    logic [47:0] y;
    y = v[79:32];
    if (m[1]) y = m[0] ? {v[55:48], v[63:56], v[71:64], v[79:72], v[39:32], v[47:40]} : {v[63:48], v[79:64], v[47:32]};
    for (int i = 0; i < 6; i++) dacl_mem_model_i.mem[a + i] = y[47 - 8 * i -: 8];
    y = {v[31:0], 16'h0000};
    for (int i = 0; i < 6; i++) dacl_mem_model_i.mem[a + 6 + i] = y[47 - 8 * i -: 8];
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    results;
  end
  initial begin
    repeat (4) tick;
    resetn_i = 1;
    repeat (3) tick;
    rd(`DACL_OFS_CONTROL);
    chk(rv, `DACL_CTL_RESET);
    rd(5'h00);
    chk(rv, 16'h0000);
    for (m = 0; m < 8; m++) begin
      lat = 2'($random(seed));
      b = 2 * ({$random(seed)} % 32);
      e = m[2] ? 12 : 6;
      for (k = 0; k < 3; k++) begin
        x = {$random(seed), $random(seed), 16'($random(seed))};
        x[32] = 1'b1;
        if (k == 2) x[47:32] = 16'h0000;
        put(b + k * e, x);
        if (k < 2) exp_q.push_back(x);
      end
      wr(`DACL_OFS_NEXT_ADDR_LOWER, b[15:0]);
      wr(`DACL_OFS_NEXT_ADDR_UPPER, 16'h0000);
      wr(`DACL_OFS_CONTROL, {3'h0, m[1], 9'h000, m[2], m[0], 1'b1});
      while (exp_q.size() > 0) begin
        x = exp_q.pop_front();
        for (k = 0; k < 200 && buf_valid_o !== 1'b1; k++) tick;
        chk(buf_valid_o, 1'b1);
        chk({buf_addr_o, buf_count_o}, x[79:32]);
        if (m[2]) chk({buf_frame_o, buf_char_o}, x[31:0]);
        rd(`DACL_OFS_BYTE_COUNT);
        chk(rv, x[47:32]);
        rd(`DACL_OFS_ADDR_LOWER);
        chk(rv, x[63:48]);
        buf_done_i = 1;
        tick;
        buf_done_i = 0;
      end
      for (k = 0; k < 200 && chain_end_o !== 1'b1; k++) tick;
      chk({busy_o, chain_end_o, buf_valid_o, mem_req_o}, 4'b0100);
      rd(`DACL_OFS_NEXT_ADDR_LOWER);
      chk(rv, b + 2 * e);
      rd(`DACL_OFS_STATUS);
      chk(rv, 16'h0002);
      chk(chain_end_o, 1'b0);
      $display("mode %0d finished", m);
    end
    results;
  end
endmodule // dacl_array_chain_bench
